// >>> core/scr_sense_regs.v
/*
  sense sampling configuration and measurement result registers, two channels.
  assumes a simple synchronous byte register port (addr, write strobe, data)
  from the serial management bus engine, and a converter that hands finished
  samples with a one-cycle done pulse.
*/
`timescale 1ns/1ps
`include "scr_regs.vh"

module scr_sense_regs #(
  parameter DUAL_CHANNEL = 1,
  // decode tables for the config codes live outside; these only fix widths
  parameter TIME_W       = 3,
  parameter AVG_W        = 2,
  parameter RNG_W        = 2
) (
  // clock and reset
  input  wire                       sys_clk,
  input  wire                       arst_n,
  // register port
  input  wire [7:0]                 reg_addr,
  input  wire                       reg_wr,
  input  wire [7:0]                 reg_wdata,
  output reg  [7:0]                 reg_rdata,
  // device state
  input  wire                       standby,
  // converter side
  input  wire                       conv_done,
  input  wire [`SCR_SENSE_W-1:0]    ch1_shunt_voltage,
  input  wire [`SCR_SENSE_W-1:0]    ch2_shunt_voltage,
  input  wire [`SCR_SRC_W-1:0]      ch1_supply_voltage,
  input  wire [`SCR_SRC_W-1:0]      ch2_supply_voltage,
  output reg                        single_conversion_trigger,
  // config fields to the front end
  output wire [TIME_W-1:0]          ch1_sense_sample_time,
  output wire [AVG_W-1:0]           ch1_sense_avg_count,
  output wire [RNG_W-1:0]           ch1_sense_range_or_result,
  output wire [TIME_W-1:0]          ch2_sense_sample_time,
  output wire [AVG_W-1:0]           ch2_sense_avg_count,
  output wire [RNG_W-1:0]           ch2_sense_range_or_result
);

  localparam CH2_ON = (DUAL_CHANNEL != 0) ? 1'b1 : 1'b0;

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  reg  [7:0] ch1_cfg_reg;
  reg  [7:0] ch2_cfg_reg;
  wire [7:0] ch2_cfg_view;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch1_cfg_reg <= `SCR_CFG_RESET;
      ch2_cfg_reg <= `SCR_CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `SCR_ADDR_CH1_CFG)
        ch1_cfg_reg <= reg_wdata & `SCR_CFG_MASK;
      if (reg_addr == `SCR_ADDR_CH2_CFG)
        ch2_cfg_reg <= reg_wdata & `SCR_CFG_MASK;
    end
  end

  assign ch2_cfg_view = CH2_ON ? ch2_cfg_reg : 8'h00;

  assign ch1_sense_sample_time     = ch1_cfg_reg[`SCR_CFG_TIME_HI:`SCR_CFG_TIME_LO];
  assign ch1_sense_avg_count       = ch1_cfg_reg[`SCR_CFG_AVG_HI:`SCR_CFG_AVG_LO];
  assign ch1_sense_range_or_result = ch1_cfg_reg[`SCR_CFG_RNG_HI:`SCR_CFG_RNG_LO];
  assign ch2_sense_sample_time     = ch2_cfg_view[`SCR_CFG_TIME_HI:`SCR_CFG_TIME_LO];
  assign ch2_sense_avg_count       = ch2_cfg_view[`SCR_CFG_AVG_HI:`SCR_CFG_AVG_LO];
  assign ch2_sense_range_or_result = ch2_cfg_view[`SCR_CFG_RNG_HI:`SCR_CFG_RNG_LO];

  // ***************************************************************
  // one-shot trigger
  // ***************************************************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      single_conversion_trigger <= 1'b0;
    else
      single_conversion_trigger <= reg_wr && standby &&
                                   (reg_addr == `SCR_ADDR_ONE_SHOT);
  end

  // ***************************************************************
  // result registers
  // ***************************************************************
  wire [`SCR_RES_W-1:0] ch1_sense_res;
  wire [`SCR_RES_W-1:0] ch2_sense_res;
  wire [`SCR_RES_W-1:0] ch1_src_res;
  wire [`SCR_RES_W-1:0] ch2_src_res;

  // 12-bit sense words, left aligned
  scr_result_hold #(.DW(`SCR_SENSE_W), .PAD(`SCR_SENSE_PAD)) u_ch1_sense (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (conv_done),
    .present   (1'b1),
    .sample    (ch1_shunt_voltage),
    .value_reg (ch1_sense_res)
  );
  scr_result_hold #(.DW(`SCR_SENSE_W), .PAD(`SCR_SENSE_PAD)) u_ch2_sense (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (conv_done),
    .present   (CH2_ON),
    .sample    (ch2_shunt_voltage),
    .value_reg (ch2_sense_res)
  );
  // 11-bit unsigned source words, 19.531 mV a count
  scr_result_hold #(.DW(`SCR_SRC_W), .PAD(`SCR_SRC_PAD)) u_ch1_src (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (conv_done),
    .present   (1'b1),
    .sample    (ch1_supply_voltage),
    .value_reg (ch1_src_res)
  );
  scr_result_hold #(.DW(`SCR_SRC_W), .PAD(`SCR_SRC_PAD)) u_ch2_src (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .load      (conv_done),
    .present   (CH2_ON),
    .sample    (ch2_supply_voltage),
    .value_reg (ch2_src_res)
  );

  // ***************************************************************
  // read mux
  // ***************************************************************
  // result addresses are never decoded for write, so host writes do nothing
  always @* begin
    case (reg_addr)
      `SCR_ADDR_CH1_CFG:      reg_rdata = ch1_cfg_reg;
      `SCR_ADDR_CH2_CFG:      reg_rdata = ch2_cfg_view;
      `SCR_ADDR_CH1_SENSE_HI: reg_rdata = ch1_sense_res[15:8];
      `SCR_ADDR_CH1_SENSE_LO: reg_rdata = ch1_sense_res[7:0];
      `SCR_ADDR_CH2_SENSE_HI: reg_rdata = ch2_sense_res[15:8];
      `SCR_ADDR_CH2_SENSE_LO: reg_rdata = ch2_sense_res[7:0];
      `SCR_ADDR_CH1_SRC_HI:   reg_rdata = ch1_src_res[15:8];
      `SCR_ADDR_CH1_SRC_LO:   reg_rdata = ch1_src_res[7:0];
      `SCR_ADDR_CH2_SRC_HI:   reg_rdata = ch2_src_res[15:8];
      `SCR_ADDR_CH2_SRC_LO:   reg_rdata = ch2_src_res[7:0];
      default:                reg_rdata = 8'h00;
    endcase
  end

endmodule

// >>> core/scr_regs.vh
/*
  register map constants for the sense configuration and result slice.
  assumes a byte-wide register port with 8-bit addresses.
*/
// Behaviour
// - each sense config register holds a 3-bit sample-time selector in bits 6:4 that sets result resolution.
// - bits 3:2 of each sense config register pick how many consecutive sense samples are averaged.
// - bits 1:0 of each sense config register pick the sense full-scale range.
// - bit 7 of each sense config register reads zero and ignores writes.
// - at reset each sense config register loads sample time 101, averaging 00, range 11, bit 7 clear.
// - channel 1 sense config sits at 0BH and channel 2 at 0CH, both read/write.
// - each sense result is 12 bits in bits 15:4 of a 16-bit register, bits 3:0 read zero.
// - channel 1 sense result is at 0DH/0EH (high/low) and channel 2 at 0FH/10H.
// - each source result is 11 bits in bits 15:5 of a 16-bit register, bits 4:0 read zero.
// - the source result is unsigned with 19.531 mV per count, code 400h meaning 20 V.
// - channel 1 source result is at 11H/12H and channel 2 at 13H/14H.
// - all result registers are read-only, reset to zero, and host writes do nothing.
// - on the single-channel variant all channel 2 config and result bits read zero.
// - a write of any value to the one-shot register in standby starts one conversion cycle.
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// ***************************************************************
// addresses
// ***************************************************************
`define SCR_ADDR_ONE_SHOT     8'h09
`define SCR_ADDR_CH1_CFG      8'h0B
`define SCR_ADDR_CH2_CFG      8'h0C
`define SCR_ADDR_CH1_SENSE_HI 8'h0D
`define SCR_ADDR_CH1_SENSE_LO 8'h0E
`define SCR_ADDR_CH2_SENSE_HI 8'h0F
`define SCR_ADDR_CH2_SENSE_LO 8'h10
`define SCR_ADDR_CH1_SRC_HI   8'h11
`define SCR_ADDR_CH1_SRC_LO   8'h12
`define SCR_ADDR_CH2_SRC_HI   8'h13
`define SCR_ADDR_CH2_SRC_LO   8'h14

// ***************************************************************
// config fields and reset
// ***************************************************************
`define SCR_CFG_TIME_HI  6
`define SCR_CFG_TIME_LO  4
`define SCR_CFG_AVG_HI   3
`define SCR_CFG_AVG_LO   2
`define SCR_CFG_RNG_HI   1
`define SCR_CFG_RNG_LO   0
`define SCR_CFG_MASK     8'h7F
`define SCR_CFG_RESET    8'h53

// ***************************************************************
// result layout
// ***************************************************************
`define SCR_SENSE_W      12
`define SCR_SENSE_PAD    4
`define SCR_SRC_W        11
`define SCR_SRC_PAD      5
`define SCR_RES_W        16

`endif

// >>> core/scr_result_hold.v
/*
  one result register: latches a sample left-aligned in a 16-bit word.
  assumes data and strobe come from the conversion logic on sys_clk.
*/
`timescale 1ns/1ps
`include "scr_regs.vh"

module scr_result_hold #(
  parameter DW  = 12,
  parameter PAD = 4
) (
  // clock and reset
  input  wire                   sys_clk,
  input  wire                   arst_n,
  // sample side
  input  wire                   load,
  input  wire                   present,
  input  wire [DW-1:0]          sample,
  // register side
  output reg  [`SCR_RES_W-1:0]  value_reg
);

  // both bytes are taken in one edge, so a two-byte read with no load between its bytes sees one sample
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= 16'h0000;
    end else if (load) begin
      if (present)
        value_reg <= {sample, {PAD{1'b0}}};
      else
        value_reg <= 16'h0000;
    end
  end

endmodule

// >>> tb/scr_host_model.sv
/* host model on the byte register port.
   assumes one sys_clk; requests change after the rising edge. */
`timescale 1ns/1ps
module scr_host_model (
  // register port
  input  wire       sys_clk,
  output reg  [7:0] reg_addr  = 8'h00,
  output reg        reg_wr    = 1'b0,
  output reg  [7:0] reg_wdata = 8'h00
);
  task put(input [7:0] a, input w, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wr    <= w;
      // idle data is scrambled, any value may start a one-shot
      reg_wdata <= w ? d : ~reg_wdata;
    end
  endtask
endmodule

// >>> tb/scr_sense_regs_assertions.sv
/* checker for the register port of scr_sense_regs.
   assumes combinational read data and one clock. */
`timescale 1ns/1ps
`include "scr_regs.vh"
module scr_sense_regs_assertions (
  // watched ports
  input wire                    sys_clk,
  input wire                    arst_n,
  input wire [7:0]              reg_addr,
  input wire                    reg_wr,
  input wire [7:0]              reg_wdata,
  input wire [7:0]              reg_rdata,
  input wire                    standby,
  input wire                    conv_done,
  input wire [`SCR_SENSE_W-1:0] ch1_shunt_voltage,
  input wire                    single_conversion_trigger
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_shot;
    reg_wr && reg_addr == 8'h09 && standby;
  endsequence
  sequence s_cfg_wr;
    reg_wr && reg_addr == 8'h0B ##1 reg_addr == 8'h0B;
  endsequence
  sequence s_conv;
    conv_done ##1 !conv_done ##1 reg_addr == 8'h0D;
  endsequence
  chk_shot_fire: assert property (s_shot |=> single_conversion_trigger)
    else $error("trigger missing");
  chk_shot_quiet: assert property (!(reg_wr && reg_addr == 8'h09 && standby)
    |=> !single_conversion_trigger) else $error("stray trigger");
  chk_cfg_rdback: assert property (s_cfg_wr |-> reg_rdata == ($past(reg_wdata) & 8'h7F))
    else $error("cfg readback");
  chk_cfg_top: assert property (reg_addr inside {8'h0B, 8'h0C} |-> !reg_rdata[7])
    else $error("cfg bit 7 set");
  chk_sense_pad: assert property (reg_addr inside {8'h0E, 8'h10} |-> reg_rdata[3:0] == 4'h0)
    else $error("sense pad");
  chk_src_pad: assert property (reg_addr inside {8'h12, 8'h14} |-> reg_rdata[4:0] == 5'h00)
    else $error("source pad");
  chk_sense_load: assert property (s_conv |-> reg_rdata == ($past(ch1_shunt_voltage, 2) >> 4))
    else $error("sense load");
  chk_result_hold: assert property (!conv_done ##1 reg_addr == 8'h0D && $past(reg_addr) == 8'h0D
    |-> $stable(reg_rdata)) else $error("result moved");
endmodule
bind scr_sense_regs scr_sense_regs_assertions chk_u (.*);

// >>> tb/tb.sv
/* self-checking bench for scr_sense_regs, host model on the port.
   assumes a 100 ns clock and the dual channel build. */
`timescale 1ns/1ps
module tb;
  reg         sys_clk = 1'b0;
  reg         arst_n  = 1'b0;
  reg         standby = 1'b0;
  reg         conv_done = 1'b0;
  reg  [45:0] smp = 46'h0;
  wire [11:0] ch1_shunt_voltage = smp[45:34];
  wire [11:0] ch2_shunt_voltage = smp[33:22];
  wire [10:0] ch1_supply_voltage = smp[21:11];
  wire [10:0] ch2_supply_voltage = smp[10:0];
  wire [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, single_conversion_trigger;
  wire [2:0]  ch1_sense_sample_time, ch2_sense_sample_time;
  wire [1:0]  ch1_sense_avg_count, ch2_sense_avg_count;
  wire [1:0]  ch1_sense_range_or_result, ch2_sense_range_or_result;
  wire [7:0]  solo_rdata;
  wire [2:0]  solo_time;
  wire [1:0]  solo_avg, solo_rng;
  reg  [63:0] exw;
  reg  [31:0] rnd;
  integer     n_fail = 0, n_checks = 0, seed = 26226, cyc = 0, i, k;
  scr_host_model host_u (.*);
  scr_sense_regs dut_u (.*);
  // single-channel build on the same stimulus, channel 2 must stay dark
  scr_sense_regs #(.DUAL_CHANNEL(0)) solo_u (
    .sys_clk                   (sys_clk),
    .arst_n                    (arst_n),
    .reg_addr                  (reg_addr),
    .reg_wr                    (reg_wr),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (solo_rdata),
    .standby                   (standby),
    .conv_done                 (conv_done),
    .ch1_shunt_voltage         (ch1_shunt_voltage),
    .ch2_shunt_voltage         (ch2_shunt_voltage),
    .ch1_supply_voltage        (ch1_supply_voltage),
    .ch2_supply_voltage        (ch2_supply_voltage),
    .single_conversion_trigger (),
    .ch1_sense_sample_time     (),
    .ch1_sense_avg_count       (),
    .ch1_sense_range_or_result (),
    .ch2_sense_sample_time     (solo_time),
    .ch2_sense_avg_count       (solo_avg),
    .ch2_sense_range_or_result (solo_rng)
  );
  initial forever #50 sys_clk = ~sys_clk;
  task check(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      host_u.put(a, 1'b0, 8'h00);
      @(negedge sys_clk);
      check({8'h00, reg_rdata}, {8'h00, e});
    end
  endtask
  // samples are scrambled after the load edge so a live pass-through shows
  task conv(input [45:0] s);
    begin
      @(posedge sys_clk);
      smp <= s;
      conv_done <= 1'b1;
      exw = {s[45:34], 4'h0, s[33:22], 4'h0, s[21:11], 5'h00, s[10:0], 5'h00};
      @(posedge sys_clk);
      smp <= ~s;
      conv_done <= 1'b0;
    end
  endtask
  function [7:0] exp_res(input [7:0] a);
    reg [15:0] w;
    begin
      w = exw[63 - 16 * ((a - 8'h0D) >> 1) -: 16];
      exp_res = a[0] ? w[15:8] : w[7:0];
    end
  endfunction
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(8'h0B, 8'h53);
    rd(8'h0C, 8'h53);
    check({ch2_sense_sample_time, ch2_sense_avg_count, ch2_sense_range_or_result}, 7'h53);
    for (i = 13; i <= 20; i = i + 1)
      rd(i[7:0], 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = (i < 2) ? {32{i[0]}} : $random(seed);
      host_u.put(8'h0B + i[0], 1'b1, rnd[7:0]);
      rd(8'h0B + i[0], rnd[7:0] & 8'h7F);
      check({8'h00, solo_rdata}, i[0] ? 16'h0000 : {8'h00, rnd[7:0] & 8'h7F});
      check({solo_time, solo_avg, solo_rng}, 7'h00);
      check(i[0] ? {ch2_sense_sample_time, ch2_sense_avg_count, ch2_sense_range_or_result}
                 : {ch1_sense_sample_time, ch1_sense_avg_count, ch1_sense_range_or_result},
            rnd[6:0]);
    end
    for (k = 0; k < 6; k = k + 1) begin
      rnd = $random(seed);
      conv(k == 0 ? {12'hFFF, 12'h801, 11'h400, 11'h001} : {rnd, rnd[13:0]});
      for (i = 13; i <= 20; i = i + 1) begin
        rd(i[7:0], exp_res(i[7:0]));
        check({8'h00, solo_rdata},
              (i == 15 || i == 16 || i >= 19) ? 16'h0000 : {8'h00, exp_res(i[7:0])});
      end
    end
    host_u.put(8'h0D, 1'b1, 8'h5A);
    rd(8'h0D, exp_res(8'h0D));
    host_u.put(8'h40, 1'b1, 8'hA5);
    rd(8'h40, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge sys_clk);
      standby <= ~i[0];
      host_u.put(8'h09, 1'b1, rnd[7:0]);
      host_u.put(8'h09, 1'b0, 8'h00);
      @(negedge sys_clk);
      check({15'h0, single_conversion_trigger}, {15'h0, ~i[0]});
      @(negedge sys_clk);
      check({15'h0, single_conversion_trigger}, 16'h0000);
    end
    give_verdict;
  end
endmodule
